//--- design/plg_pkg.sv
// Functional notes
// - per-indicator polarity bit, strap default high
// - aux force-enable drives aux forced value
// - indicator two force, value, polarity bits
// - indicator one force, value, polarity bits
// - indicator zero force, value, polarity bits
// - blink select 50/100/200/500 ms, reset 2
// - stretch bypass drives raw event sources
// - quick negotiation enable and timer select
// - declare full duplex on parallel detect
// - status clear enable clears phy status
// - robust and quick crossover enables
// - pin bit selects interrupt or powerdown
// - force-interrupt bit asserts interrupt; drives the pin only when the pin bit selects interrupt
// - gigabit-only negotiation when manual 1G
// - cable test go, self-clear, done/fail flags
// - soft full reset restores defaults, self-clears
// - soft restart keeps registers, self-clears
// - four-bit source select per indicator
package plg_pkg;
  localparam int AW = 6;
  localparam int DW = 16;

  localparam logic [AW-1:0] OFF_SRC   = 6'h18;
  localparam logic [AW-1:0] OFF_POL   = 6'h19;
  localparam logic [AW-1:0] OFF_BLINK = 6'h1a;
  localparam logic [AW-1:0] OFF_CFG4  = 6'h1e;
  localparam logic [AW-1:0] OFF_CTRL  = 6'h1f;
  localparam logic [AW-1:0] OFF_ISTAT = 6'h20;
  localparam logic [AW-1:0] OFF_IMASK = 6'h21;

  localparam logic [DW-1:0] RST_SRC   = 16'h6000;
  localparam logic [DW-1:0] RST_POL   = 16'h4444;
  localparam logic [DW-1:0] RST_BLINK = 16'h0002;
  localparam logic [DW-1:0] RST_CFG4  = 16'h0012;
  localparam logic [DW-1:0] RST_CTRL  = 16'h0000;

  localparam logic [DW-1:0] WMSK_POL   = 16'h7777;
  localparam logic [DW-1:0] WMSK_BLINK = 16'h0007;
  localparam logic [DW-1:0] WMSK_CFG4  = 16'hfff8;
  localparam logic [DW-1:0] WMSK_CTRL  = 16'h3fff;

  // indicator i: force enable 4i, forced value 4i+1, polarity 4i+2
  localparam int NLAMP  = 4;
  localparam int B_FEN  = 0;
  localparam int B_FVAL = 1;
  localparam int B_POL  = 2;

  localparam int B_BYPASS   = 2;
  localparam int B_RATE     = 0;
  localparam int B_QNEG     = 14;
  localparam int B_QSEL     = 12;
  localparam int B_PDFD     = 11;
  localparam int B_STCLR    = 10;
  localparam int B_ROBUST   = 9;
  localparam int B_QX       = 8;
  localparam int B_INT_OE   = 7;
  localparam int B_FORCE_IRQ = 6;
  localparam int B_G1       = 3;
  localparam int B_TFAIL    = 2;
  localparam int B_TDONE    = 1;
  localparam int B_TGO      = 0;
  localparam int B_SWRST    = 15;
  localparam int B_SWRS     = 14;

  // interrupt status / mask layout
  localparam int NIRQ    = 3;
  localparam int IB_DONE = 0;
  localparam int IB_FAIL = 1;
  localparam int IB_PDN  = 2;

  localparam int CLK_KHZ     = 20000;
  localparam int BLINK_MS_00 = 50;
  localparam int BLINK_MS_01 = 100;
  localparam int BLINK_MS_10 = 200;
  localparam int BLINK_MS_11 = 500;
  localparam int STRETCH_MS  = 50;
  localparam logic [1:0] BOOT_CAPTURE = 2'h1;
  localparam logic [1:0] BOOT_APPLY   = 2'h2;
  localparam logic [1:0] BOOT_DONE    = 2'h3;

  typedef enum logic [3:0] {
    SRC_LINK, SRC_ACT, SRC_TXACT, SRC_RXACT, SRC_COL, SRC_L1000,
    SRC_L100, SRC_L10, SRC_L10_100, SRC_L100_1000, SRC_FDX,
    SRC_LINK_BLINK, SRC_NONE, SRC_ERR, SRC_RXERR, SRC_RSVD
  } plg_src_t;

  typedef struct packed {
    logic link_ok;
    logic rx_act;
    logic tx_act;
    logic col;
    logic link1000;
    logic link100;
    logic link10;
    logic fdx;
    logic rx_er;
    logic tx_er;
  } plg_evt_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } plg_bus_t;

  typedef struct packed {
    logic       quick_negotiation_enable;
    logic [1:0] quick_negotiation_timer_select;
    logic       parallel_detect_full_duplex;
    logic       status_clear_enable;
    logic       robust_crossover_enable;
    logic       quick_crossover_enable;
    logic       gigabit_only_negotiation;
  } plg_ctl_t;
endpackage

//--- design/plg_lamp.sv
`timescale 1ns/10ps
module plg_lamp
  import plg_pkg::*;
#(
  parameter int STRETCH_CYC = STRETCH_MS * CLK_KHZ
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // event and blink
  input  wire logic raw,
  input  wire logic link,
  input  wire logic blink_src,
  input  wire logic blink_phase,
  // control bits
  input  wire logic bypass,
  input  wire logic force_en,
  input  wire logic force_val,
  input  wire logic polarity,
  // lamp
  output logic      lamp_ff
);
  localparam int CW = $clog2(STRETCH_CYC + 1);
  localparam logic [CW-1:0] RELOAD = CW'(STRETCH_CYC - 1);

  logic [CW-1:0] cnt_ff;
  logic          ev;
  logic          level;
  logic          nxt_lamp;

  // short activity bursts would be invisible without stretching
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else if (raw) begin
      cnt_ff <= RELOAD;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  always_comb begin
    ev = bypass ? raw : (raw | (cnt_ff != '0));
    level = blink_src ? (link & ~(ev & blink_phase)) : ev;
    nxt_lamp = force_en ? force_val : level;
    nxt_lamp = polarity ? nxt_lamp : ~nxt_lamp;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lamp_ff <= 1'b0;
    end else begin
      lamp_ff <= nxt_lamp;
    end
  end
endmodule

//--- design/plg_regs.sv
`timescale 1ns/10ps
module plg_regs
  import plg_pkg::*;
#(
  parameter int BLINK_CYC_00 = BLINK_MS_00 * CLK_KHZ,
  parameter int BLINK_CYC_01 = BLINK_MS_01 * CLK_KHZ,
  parameter int BLINK_CYC_10 = BLINK_MS_10 * CLK_KHZ,
  parameter int BLINK_CYC_11 = BLINK_MS_11 * CLK_KHZ,
  parameter int STRETCH_CYC  = STRETCH_MS * CLK_KHZ
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // register port
  input  wire plg_bus_t          bus_req,
  output logic [DW-1:0]          rdata_ff,
  // straps
  input  wire logic [NLAMP-1:0]  strap_polarity,
  input  wire logic [11:0]       strap_source,
  // phy state
  input  wire plg_evt_t          events,
  input  wire logic              manual_speed_1g,
  input  wire logic              cable_test_finished,
  input  wire logic              cable_test_fail_in,
  // configuration to phy engines
  output plg_ctl_t               ctl,
  output logic                   cable_test_go,
  output logic                   phy_reset,
  output logic                   phy_restart,
  // interrupt and shared pin
  output logic                   irq_ff,
  input  wire logic              irq_pin_in,
  output logic                   irq_pin_out,
  output logic                   irq_pin_oe_n,
  output logic                   powerdown_req,
  // indicators: 0 zero, 1 one, 2 two, 3 aux
  output logic [NLAMP-1:0]       indicators
);
  localparam int TW = $clog2(BLINK_CYC_11 + 1);

  logic [DW-1:0]      src_ff;
  logic [DW-1:0]      pol_ff;
  logic [DW-1:0]      blink_ff;
  logic [DW-1:0]      cfg4_ff;
  logic [DW-1:0]      ctrl_ff;
  logic [NIRQ-1:0]    istat_ff;
  logic [NIRQ-1:0]    imask_ff;
  logic               go_ff;
  logic               done_ff;
  logic               fail_ff;
  logic               swrst_ff;
  logic               swrs_ff;
  logic [1:0]         boot_ff;
  logic [NLAMP-1:0]   spol_s1_ff;
  logic [NLAMP-1:0]   spol_s2_ff;
  logic [11:0]        ssrc_s1_ff;
  logic [11:0]        ssrc_s2_ff;
  logic [NLAMP-1:0]   spol_ff;
  logic [11:0]        ssrc_ff;
  logic               pin_s1_ff;
  logic               pin_s2_ff;
  logic               pdn_ff;
  logic [TW-1:0]      tick_ff;
  logic               phase_ff;
  logic               restore;
  logic               pdn_now;
  logic [NIRQ-1:0]    ev_irq;
  logic               irq_any;
  logic [DW-1:0]      nxt_rdata;
  logic [NLAMP-1:0]   raw;
  logic [NLAMP-1:0]   blk;

  function automatic logic wr_at(input plg_bus_t b,
                                 input logic [AW-1:0] off);
    wr_at = b.wr && (b.addr == off);
  endfunction

  function automatic logic [DW-1:0] pol_default(
      input logic [NLAMP-1:0] sp);
    logic [DW-1:0] v;
    v = RST_POL;
    for (int i = 0; i < NLAMP; i++) begin
      v[4*i+B_POL] = sp[i];
    end
    pol_default = v;
  endfunction

  // picks the event that drives one indicator
  function automatic logic src_event(input logic [3:0] sel,
                                     input plg_evt_t e);
    case (plg_src_t'(sel))
      SRC_LINK:       src_event = e.link_ok;
      SRC_ACT:        src_event = e.rx_act | e.tx_act;
      SRC_TXACT:      src_event = e.tx_act;
      SRC_RXACT:      src_event = e.rx_act;
      SRC_COL:        src_event = e.col;
      SRC_L1000:      src_event = e.link1000;
      SRC_L100:       src_event = e.link100;
      SRC_L10:        src_event = e.link10;
      SRC_L10_100:    src_event = e.link10 | e.link100;
      SRC_L100_1000:  src_event = e.link100 | e.link1000;
      SRC_FDX:        src_event = e.fdx;
      SRC_LINK_BLINK: src_event = e.rx_act | e.tx_act;
      SRC_ERR:        src_event = e.rx_er | e.tx_er;
      SRC_RXERR:      src_event = e.rx_er;
      default:        src_event = 1'b0;
    endcase
  endfunction

  function automatic logic [TW-1:0] half_period(input logic [1:0] r);
    case (r)
      2'h0:    half_period = TW'(BLINK_CYC_00 / 2);
      2'h1:    half_period = TW'(BLINK_CYC_01 / 2);
      2'h2:    half_period = TW'(BLINK_CYC_10 / 2);
      default: half_period = TW'(BLINK_CYC_11 / 2);
    endcase
  endfunction

  // straps are pins: two flops before anything looks at them; no reset,
  // so they have settled on the strap level when boot capture samples
  always_ff @(posedge clock) begin
    spol_s1_ff <= strap_polarity;
    spol_s2_ff <= spol_s1_ff;
    ssrc_s1_ff <= strap_source;
    ssrc_s2_ff <= ssrc_s1_ff;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
    end else begin
      pin_s1_ff <= irq_pin_in;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // straps latched once after reset release, kept for soft reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      boot_ff <= '0;
      spol_ff <= '1;
      ssrc_ff <= '0;
    end else begin
      if (boot_ff != BOOT_DONE) begin
        boot_ff <= boot_ff + 1'b1;
      end
      if (boot_ff == BOOT_CAPTURE) begin
        spol_ff <= spol_s2_ff;
        ssrc_ff <= ssrc_s2_ff;
      end
    end
  end

  assign restore = (boot_ff == BOOT_APPLY) || swrst_ff;

  // plain read/write configuration registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      src_ff   <= RST_SRC;
      pol_ff   <= RST_POL;
      blink_ff <= RST_BLINK;
      cfg4_ff  <= RST_CFG4;
      ctrl_ff  <= RST_CTRL;
      imask_ff <= '0;
    end else if (restore) begin
      src_ff   <= {RST_SRC[15:12], ssrc_ff};
      pol_ff   <= pol_default(spol_ff);
      blink_ff <= RST_BLINK;
      cfg4_ff  <= RST_CFG4;
      ctrl_ff  <= RST_CTRL;
      imask_ff <= '0;
    end else begin
      if (wr_at(bus_req, OFF_SRC)) begin
        src_ff <= bus_req.wdata;
      end
      if (wr_at(bus_req, OFF_POL)) begin
        pol_ff <= bus_req.wdata & WMSK_POL;
      end
      if (wr_at(bus_req, OFF_BLINK)) begin
        blink_ff <= bus_req.wdata & WMSK_BLINK;
      end
      if (wr_at(bus_req, OFF_CFG4)) begin
        cfg4_ff <= bus_req.wdata & WMSK_CFG4;
      end
      if (wr_at(bus_req, OFF_CTRL)) begin
        ctrl_ff <= bus_req.wdata & WMSK_CTRL;
      end
      if (wr_at(bus_req, OFF_IMASK)) begin
        imask_ff <= bus_req.wdata[NIRQ-1:0];
      end
    end
  end

  // cable test: go clears itself when the test engine reports
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      go_ff   <= 1'b0;
      done_ff <= 1'b1;
      fail_ff <= 1'b0;
    end else if (restore) begin
      go_ff   <= 1'b0;
      done_ff <= 1'b1;
      fail_ff <= 1'b0;
    end else if (wr_at(bus_req, OFF_CFG4) && bus_req.wdata[B_TGO]) begin
      go_ff   <= 1'b1;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else if (go_ff && cable_test_finished) begin
      go_ff   <= 1'b0;
      done_ff <= 1'b1;
      fail_ff <= cable_test_fail_in;
    end
  end

  // reset and restart bits read back high for one cycle only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      swrst_ff <= 1'b0;
      swrs_ff  <= 1'b0;
    end else begin
      swrst_ff <= wr_at(bus_req, OFF_CTRL) & bus_req.wdata[B_SWRST];
      swrs_ff  <= wr_at(bus_req, OFF_CTRL) & bus_req.wdata[B_SWRS];
    end
  end

  assign phy_reset   = swrst_ff;
  assign phy_restart = swrs_ff;

  // powerdown is the pin low while it serves as an input
  assign pdn_now = ~cfg4_ff[B_INT_OE] & ~pin_s2_ff;
  assign powerdown_req = pdn_ff;

  always_comb begin
    ev_irq          = '0;
    ev_irq[IB_DONE] = go_ff & cable_test_finished;
    ev_irq[IB_FAIL] = go_ff & cable_test_finished & cable_test_fail_in;
    ev_irq[IB_PDN]  = pdn_now & ~pdn_ff;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      istat_ff <= '0;
      pdn_ff   <= 1'b0;
    end else begin
      pdn_ff <= pdn_now;
      if (restore) begin
        istat_ff <= ev_irq;
      end else if (wr_at(bus_req, OFF_ISTAT)) begin
        istat_ff <= (istat_ff & ~bus_req.wdata[NIRQ-1:0]) | ev_irq;
      end else begin
        istat_ff <= istat_ff | ev_irq;
      end
    end
  end

  assign irq_any = |(istat_ff & imask_ff);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= irq_any | cfg4_ff[B_FORCE_IRQ];
    end
  end

  // open-drain, active low: only ever pulls the pin down
  assign irq_pin_out  = 1'b0;
  assign irq_pin_oe_n = ~(cfg4_ff[B_INT_OE] & irq_ff);

  always_comb begin
    ctl.quick_negotiation_enable       = cfg4_ff[B_QNEG];
    ctl.quick_negotiation_timer_select = cfg4_ff[B_QSEL +: 2];
    ctl.parallel_detect_full_duplex    = cfg4_ff[B_PDFD];
    ctl.status_clear_enable            = cfg4_ff[B_STCLR];
    ctl.robust_crossover_enable        = cfg4_ff[B_ROBUST];
    ctl.quick_crossover_enable         = cfg4_ff[B_QX];
    ctl.gigabit_only_negotiation       =
      cfg4_ff[B_G1] & manual_speed_1g;
  end

  assign cable_test_go = go_ff;

  // blink phase toggles every half period of the selected rate
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_ff  <= '0;
      phase_ff <= 1'b0;
    end else if (tick_ff >= half_period(blink_ff[B_RATE +: 2]) - 1'b1) begin
      tick_ff  <= '0;
      phase_ff <= ~phase_ff;
    end else begin
      tick_ff <= tick_ff + 1'b1;
    end
  end

  always_comb begin
    for (int i = 0; i < NLAMP; i++) begin
      raw[i] = src_event(src_ff[4*i +: 4], events);
      blk[i] = (plg_src_t'(src_ff[4*i +: 4]) == SRC_LINK_BLINK);
    end
  end

  for (genvar g = 0; g < NLAMP; g++) begin : g_lamp
    plg_lamp #(
      .STRETCH_CYC (STRETCH_CYC)
    ) u_lamp (
      .clock       (clock),
      .nrst        (nrst),
      .raw         (raw[g]),
      .link        (events.link_ok),
      .blink_src   (blk[g]),
      .blink_phase (phase_ff),
      .bypass      (blink_ff[B_BYPASS]),
      .force_en    (pol_ff[4*g+B_FEN]),
      .force_val   (pol_ff[4*g+B_FVAL]),
      .polarity    (pol_ff[4*g+B_POL]),
      .lamp_ff     (indicators[g])
    );
  end

  always_comb begin
    case (bus_req.addr)
      OFF_SRC:   nxt_rdata = src_ff;
      OFF_POL:   nxt_rdata = pol_ff;
      OFF_BLINK: nxt_rdata = blink_ff;
      OFF_CFG4: begin
        nxt_rdata          = cfg4_ff;
        nxt_rdata[B_TFAIL] = fail_ff;
        nxt_rdata[B_TDONE] = done_ff;
        nxt_rdata[B_TGO]   = go_ff;
      end
      OFF_CTRL: begin
        nxt_rdata          = ctrl_ff;
        nxt_rdata[B_SWRST] = swrst_ff;
        nxt_rdata[B_SWRS]  = swrs_ff;
      end
      OFF_ISTAT: nxt_rdata = {{(DW-NIRQ){1'b0}}, istat_ff};
      OFF_IMASK: nxt_rdata = {{(DW-NIRQ){1'b0}}, imask_ff};
      default:   nxt_rdata = '0;
    endcase
  end

  // read data exists only in the cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= bus_req.rd ? nxt_rdata : '0;
    end
  end
endmodule

//--- sim/plg_regs_asserts.sv
`timescale 1ns/10ps
module plg_regs_asserts
  import plg_pkg::*;
(
  // clock and reset
  input wire logic             clock,
  input wire logic             nrst,
  // register port and phy side
  input wire plg_bus_t         bus_req,
  input wire plg_ctl_t         ctl,
  input wire logic             manual_speed_1g,
  input wire logic             cable_test_finished,
  input wire logic             cable_test_go,
  input wire logic             phy_reset,
  input wire logic             phy_restart,
  // interrupt, pin and lamps
  input wire logic             irq_ff,
  input wire logic             irq_pin_oe_n,
  input wire logic             powerdown_req,
  input wire logic [NLAMP-1:0] indicators
);
  logic wcfg;
  logic wctl;
  assign wcfg = bus_req.wr && bus_req.addr == OFF_CFG4;
  assign wctl = bus_req.wr && bus_req.addr == OFF_CTRL;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_qneg;
    logic v;
    (wcfg, v = bus_req.wdata[B_QNEG]) |=> ctl.quick_negotiation_enable == v;
  endproperty
  property p_lamp0;
    logic v;
    (bus_req.wr && bus_req.addr == OFF_POL && bus_req.wdata[0],
     v = bus_req.wdata[1] ~^ bus_req.wdata[2]) |-> ##2 indicators[0] == v;
  endproperty

  qneg_load_a: assert property (p_qneg)
    else $error("quick negotiation enable not loaded");
  lamp_force_a: assert property (p_lamp0)
    else $error("indicator zero ignores forced value");
  gig_only_a: assert property (
    ctl.gigabit_only_negotiation |-> manual_speed_1g)
    else $error("gigabit-only set without manual 1G");
  test_start_a: assert property (
    wcfg && bus_req.wdata[B_TGO] |=> cable_test_go)
    else $error("cable test did not start");
  test_end_a: assert property (
    cable_test_go && cable_test_finished && !(wcfg && bus_req.wdata[B_TGO])
    |=> !cable_test_go)
    else $error("cable test go did not self-clear");
  full_reset_a: assert property (
    wctl && bus_req.wdata[B_SWRST] |=> phy_reset ##1 !phy_reset)
    else $error("soft full reset pulse wrong");
  restart_pulse_a: assert property (
    wctl && bus_req.wdata[B_SWRS] |=> phy_restart ##1 !phy_restart)
    else $error("soft restart pulse wrong");
  force_irq_a: assert property (
    wcfg && bus_req.wdata[7:6] == 2'h3 |-> ##2 irq_ff && !irq_pin_oe_n)
    else $error("forced interrupt not driven on pin");
  pin_output_a: assert property (
    wcfg && bus_req.wdata[B_INT_OE] |-> ##2 !powerdown_req)
    else $error("powerdown taken while pin is an output");

  cover property (cable_test_go && cable_test_finished);
  cover property (phy_reset);
  cover property (!irq_pin_oe_n);
endmodule

bind plg_regs plg_regs_asserts plg_regs_asserts_inst (
  .clock, .nrst, .bus_req, .ctl, .manual_speed_1g, .cable_test_finished,
  .cable_test_go, .phy_reset, .phy_restart, .irq_ff, .irq_pin_oe_n,
  .powerdown_req, .indicators);

//--- sim/plg_phy_model.sv
`timescale 1ns/10ps
module plg_phy_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // device side
  input  wire logic go,
  input  wire logic oe_n,
  input  wire logic pin_out,
  output logic      fin,
  output logic      fres,
  output logic      pin,
  // scenario controls
  input  wire logic slow,
  input  wire logic fail,
  input  wire logic pd
);
  int cnt;
  // pull-up on the shared pin: low when either party pulls it
  assign pin = (oe_n || pin_out) && !pd;
  // result is only meaningful beside the done pulse
  assign fres = fin ? fail : !fail;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      fin <= 1'b0;
    end else begin
      fin <= 1'b0;
      cnt <= 0;
      if (go && !fin) begin
        cnt <= cnt + 1;
        if (cnt == (slow ? 30 : 6)) begin
          fin <= 1'b1;
          cnt <= 0;
        end
      end
    end
  end
endmodule

//--- sim/test_plg_regs.sv
`timescale 1ns/10ps
module test_plg_regs import plg_pkg::*;;
  logic             clock;
  logic             nrst;
  plg_bus_t         bus_req;
  logic [DW-1:0]    rdata_ff;
  logic [NLAMP-1:0] strap_polarity;
  logic [11:0]      strap_source;
  plg_evt_t         events;
  plg_ctl_t         ctl;
  logic             manual_speed_1g;
  logic             fin;
  logic             fres;
  logic             go;
  logic             phy_reset;
  logic             phy_restart;
  logic             irq_ff;
  logic             pin;
  logic             pin_out;
  logic             oe_n;
  logic             pdr;
  logic [NLAMP-1:0] indicators;
  logic             slow;
  logic             fail;
  logic             pd;
  int               n_errors;
  int               check_count;

  plg_regs #(.BLINK_CYC_00(8), .BLINK_CYC_01(16), .BLINK_CYC_10(32),
    .BLINK_CYC_11(40), .STRETCH_CYC(4)) plg_regs_inst (
    .clock, .nrst, .bus_req, .rdata_ff, .strap_polarity, .strap_source,
    .events, .manual_speed_1g, .cable_test_finished(fin),
    .cable_test_fail_in(fres), .ctl, .cable_test_go(go), .phy_reset,
    .phy_restart, .irq_ff, .irq_pin_in(pin), .irq_pin_out(pin_out),
    .irq_pin_oe_n(oe_n), .powerdown_req(pdr), .indicators);
  plg_phy_model plg_phy_model_inst (.clock, .nrst, .go, .oe_n, .pin_out,
    .fin, .fres, .pin, .slow, .fail, .pd);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 chk(rdata_ff, e);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic t_regs();
    logic [AW-1:0] a [6] = '{OFF_SRC, OFF_POL, OFF_BLINK, OFF_CFG4,
                             OFF_CTRL, 6'h05};
    logic [DW-1:0] r [6] = '{16'h60a0, 16'h4444, 16'h0002, 16'h0012,
                             16'h0000, 16'h0000};
    logic [DW-1:0] m [6] = '{16'h3ffe, 16'h3776, 16'h0006, 16'h3ffa,
                             16'h3ffe, 16'h0000};
    for (int i = 0; i < 6; i++) rd(a[i], r[i]);
    for (int i = 0; i < 6; i++) begin
      wr(a[i], 16'h3ffe);
      rd(a[i], m[i]);
      wr(a[i], r[i]);
    end
  endtask
  task automatic t_lamp();
    logic [DW-1:0] p [7] = '{16'h4444, 16'h0000, 16'h1111, 16'h3333,
                             16'h7777, 16'h5555, 16'h4321};
    logic [3:0]    e [7] = '{4'hf, 4'h0, 4'hf, 4'h0, 4'hf, 4'h0, 4'h9};
    wr(OFF_SRC, 16'h0000);
    wr(OFF_BLINK, 16'h0004);
    events.link_ok <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wr(OFF_POL, p[i]);
      tick(3);
      chk(16'(indicators), 16'(e[i]));
    end
    @(posedge clock);
    events.link_ok <= 1'b0;
    tick(3);
    chk(16'(indicators), 16'h0003);
    wr(OFF_POL, 16'h4444);
  endtask
  task automatic t_stretch(input logic byp, input logic [3:0] e);
    wr(OFF_SRC, 16'h1111);
    wr(OFF_BLINK, {13'h0, byp, 2'h2});
    events.rx_act <= 1'b1;
    @(posedge clock);
    events.rx_act <= 1'b0;
    tick(2);
    chk(16'(indicators), 16'(e));
  endtask
  task automatic t_src();
    logic [9:0] ev [4] = '{10'h040, 10'h020, 10'h004, 10'h001};
    wr(OFF_SRC, 16'hda54);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      events <= ev[i];
      tick(2);
      chk(16'(indicators), 16'(1 << i));
    end
  endtask
  task automatic t_blink();
    int per [4] = '{8, 16, 32, 40};
    int n;
    int e;
    logic last;
    wr(OFF_SRC, 16'h000b);
    events.link_ok <= 1'b1;
    events.rx_act <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr(OFF_BLINK, 16'(r));
      tick(4);
      n = 0;
      e = 320 / per[r];
      last = indicators[0];
      repeat (160) begin
        tick(1);
        if (indicators[0] !== last) n++;
        last = indicators[0];
      end
      // one toggle of slack for the phase at which counting starts
      chk(16'((n > e - 2 && n < e + 2) ? e : n), 16'(e));
    end
    @(posedge clock);
    events <= '0;
  endtask
  task automatic t_ctl(input logic [DW-1:0] d, input logic [7:0] e);
    @(posedge clock);
    manual_speed_1g <= 1'b1;
    wr(OFF_CFG4, d);
    tick(1);
    chk(16'(ctl), 16'(e));
    @(posedge clock);
    manual_speed_1g <= 1'b0;
    tick(1);
    chk(16'(ctl), 16'(e & 8'hfe));
  endtask
  task automatic t_cable(input logic s, input logic f, input logic [2:0] m);
    wr(OFF_ISTAT, 16'h0007);
    slow <= s;
    fail <= f;
    wr(OFF_IMASK, {13'h0, m});
    wr(OFF_CFG4, 16'h0013);
    rd(OFF_CFG4, 16'h0011);
    for (int i = 0; i < 80 && go; i++) tick(1);
    chk(16'(go), 16'h0000);
    rd(OFF_CFG4, {13'h2, f, 2'h2});
    rd(OFF_ISTAT, {14'h0, f, 1'b1});
    tick(1);
    chk(16'(irq_ff), 16'(|(m & {1'b0, f, 1'b1})));
    wr(OFF_ISTAT, 16'h0003);
    tick(2);
    chk(16'(irq_ff), 16'h0000);
  endtask
  task automatic t_pin();
    wr(OFF_CFG4, 16'h00d2);
    tick(2);
    chk({14'h0, irq_ff, oe_n}, 16'h0002);
    chk(16'(pin_out), 16'h0000);
    wr(OFF_CFG4, 16'h0052);
    tick(2);
    chk(16'(oe_n), 16'h0001);
    wr(OFF_CFG4, 16'h0012);
    wr(OFF_ISTAT, 16'h0007);
    pd <= 1'b1;
    tick(5);
    chk(16'(pdr), 16'h0001);
    rd(OFF_ISTAT, 16'h0004);
    pd <= 1'b0;
    wr(OFF_ISTAT, 16'h0004);
    rd(OFF_ISTAT, 16'h0000);
  endtask
  task automatic t_soft();
    wr(OFF_POL, 16'h0000);
    // straps are captured at boot only, so a late change must not show
    strap_polarity <= 4'h0;
    wr(OFF_CTRL, 16'h4000);
    rd(OFF_POL, 16'h0000);
    rd(OFF_CTRL, 16'h0000);
    wr(OFF_IMASK, 16'h0001);
    wr(OFF_CTRL, 16'h8000);
    tick(3);
    rd(OFF_POL, 16'h4444);
    rd(OFF_IMASK, 16'h0000);
    rd(OFF_CTRL, 16'h0000);
  endtask

  initial begin
    nrst = 1'b0;
    bus_req = '0;
    strap_polarity = 4'hf;
    strap_source = 12'h0a0;
    events = '0;
    manual_speed_1g = 1'b0;
    {slow, fail, pd} = 3'h0;
    n_errors = 0;
    check_count = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    tick(4);
    t_regs();
    t_lamp();
    t_stretch(1'b0, 4'hf);
    t_stretch(1'b1, 4'h0);
    t_src();
    t_blink();
    t_ctl(16'h5a18, 8'hb5);
    t_ctl(16'h2518, 8'h4b);
    wr(OFF_CFG4, 16'h0012);
    t_cable(1'b0, 1'b0, 3'h1);
    t_cable(1'b1, 1'b1, 3'h2);
    t_cable(1'b0, 1'b1, 3'h0);
    t_pin();
    t_soft();
    end_of_test();
  end

  // the full sequence needs about 1000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    end_of_test();
  end
endmodule
